// ===== rtl/acgw_pkg.sv
// Shared types and constants of the ASCII command gateway
package acgw_pkg;
  // Characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CASE_BIT = 8'h20;
  // Command letters, lower case
  localparam logic [7:0] LET_R = 8'h72;
  localparam logic [7:0] LET_W = 8'h77;
  localparam logic [7:0] LET_S = 8'h73;
  localparam logic [7:0] LET_C = 8'h63;
  localparam logic [7:0] LET_B = 8'h62;
  localparam logic [7:0] LET_P = 8'h70;
  localparam logic [7:0] LET_O = 8'h6f;
  localparam logic [7:0] LET_A = 8'h61;
  // Timing: one hundredth of a second at 50 ns per cycle
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_0032;
  localparam int unsigned TICK_NS = 32'h0098_9680;
  localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  // Recommended framing limits: 128 characters, 100 hundredths
  localparam logic [15:0] SIZE_LIMIT_REC = 16'h0080;
  localparam logic [15:0] TIME_LIMIT_REC = 16'h0064;
  // Route and counters
  localparam logic [3:0] ROUTE_MAX = 4'h8;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] BIT_LAST = 16'h0010;
  // Formatter positions
  localparam logic [2:0] POS_LAST_DIG = 3'h4;
  localparam logic [2:0] POS_TAIL = 3'h5;
  localparam logic [2:0] POS_DONE = 3'h6;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_READ = 4'h1,
    CMD_WRITE = 4'h2,
    CMD_SET = 4'h3,
    CMD_CLR = 4'h4,
    CMD_BIT = 4'h5,
    CMD_PRINT = 4'h6,
    CMD_OMIT = 4'h7,
    CMD_ADDR = 4'h8
  } acgw_cmd_t;

  typedef enum logic [1:0] {
    BEAT_HDR = 2'h0,
    BEAT_DATA = 2'h1,
    BEAT_END = 2'h2
  } acgw_beat_t;

  typedef struct packed {
    acgw_cmd_t cmd;
    acgw_beat_t beat;
    logic [15:0] value;
  } acgw_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic last;
  } acgw_rsp_t;

  typedef struct packed {
    logic [3:0] len;
    logic [7:0][7:0] drop;
  } acgw_route_t;
endpackage : acgw_pkg

// ===== rtl/acgw_dec_acc.sv
// Decimal digit accumulator for command parameters
`timescale 1ns/1ps
`default_nettype none
module acgw_dec_acc (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Digits
  input wire logic clear_in,
  input wire logic digit_valid_in,
  input wire logic [3:0] digit_in,
  // Result
  output logic [15:0] value_out,
  output logic active_out
);
  logic [15:0] times10;

  // Wraps modulo 65536 on overlong numbers
  assign times10 = {value_out[12:0], 3'h0} + {value_out[14:0], 1'b0};

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || clear_in) begin
      value_out <= 16'h0000;
      active_out <= 1'b0;
    end else if (digit_valid_in) begin
      value_out <= times10 + {12'h000, digit_in};
      active_out <= 1'b1;
    end
  end
endmodule : acgw_dec_acc
`default_nettype wire

// ===== rtl/acgw_dec_fmt.sv
// Word to decimal ASCII formatter with a trailing character
`timescale 1ns/1ps
`default_nettype none
module acgw_dec_fmt (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Job
  input wire logic start_in,
  input wire logic [15:0] value_in,
  input wire logic nodig_in,
  input wire logic [7:0] tail_in,
  output logic busy_out,
  // Character stream
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in
);
  logic seen_q;
  logic [2:0] pos_q;
  logic [3:0] dig_q;
  logic [15:0] rem_q;
  logic [7:0] tail_q;
  logic [15:0] pw;
  logic ge;
  logic show;

  assign pw = (pos_q == 3'h0) ? 16'h2710 :
              (pos_q == 3'h1) ? 16'h03e8 :
              (pos_q == 3'h2) ? 16'h0064 :
              (pos_q == 3'h3) ? 16'h000a : 16'h0001;
  assign ge = rem_q >= pw;
  // Leading zeros suppressed, a lone zero still printed
  assign show = (dig_q != 4'h0) || seen_q || (pos_q == acgw_pkg::POS_LAST_DIG);

  // Subtraction per cycle keeps the datapath free of dividers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      seen_q <= 1'b0;
      pos_q <= 3'h0;
      dig_q <= 4'h0;
      rem_q <= 16'h0000;
      tail_q <= 8'h00;
    end else if (start_in && !busy_out) begin
      busy_out <= 1'b1;
      rem_q <= value_in;
      pos_q <= nodig_in ? acgw_pkg::POS_TAIL : 3'h0;
      dig_q <= 4'h0;
      seen_q <= 1'b0;
      tail_q <= tail_in;
    end else if (tx_valid_out) begin
      if (tx_ready_in) begin
        tx_valid_out <= 1'b0;
        busy_out <= (pos_q != acgw_pkg::POS_DONE);
      end
    end else if (busy_out && pos_q == acgw_pkg::POS_TAIL) begin
      tx_data_out <= tail_q;
      tx_valid_out <= 1'b1;
      pos_q <= acgw_pkg::POS_DONE;
    end else if (busy_out && ge) begin
      rem_q <= rem_q - pw;
      dig_q <= dig_q + 4'h1;
    end else if (busy_out) begin
      tx_data_out <= acgw_pkg::CH_0 | {4'h0, dig_q};
      tx_valid_out <= show;
      seen_q <= seen_q || show;
      dig_q <= 4'h0;
      pos_q <= pos_q + 3'h1;
    end
  end
endmodule : acgw_dec_fmt
`default_nettype wire

// ===== rtl/acgw_gateway.sv
// ASCII command gateway: host text commands to network requests
`timescale 1ns/1ps
`default_nettype none
module acgw_gateway #(
  parameter int unsigned TICK_CYCLES = acgw_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Host receive stream
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  // Host transmit stream
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  // Framing limits, zero disables
  input wire logic [15:0] pkt_size_limit_in,
  input wire logic [15:0] pkt_time_limit_in,
  // Target route configuration
  input wire logic route_we_in,
  input wire acgw_pkg::acgw_route_t route_in,
  output acgw_pkg::acgw_route_t route_out,
  // Requests
  output acgw_pkg::acgw_req_t req_out,
  output logic net_req_valid_out,
  input wire logic net_req_ready_in,
  output logic loc_req_valid_out,
  input wire logic loc_req_ready_in,
  // Responses
  input wire logic net_rsp_valid_in,
  input wire acgw_pkg::acgw_rsp_t net_rsp_in,
  output logic net_rsp_ready_out,
  input wire logic loc_rsp_valid_in,
  input wire acgw_pkg::acgw_rsp_t loc_rsp_in,
  output logic loc_rsp_ready_out
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PARSE = 5'h02,
    ST_FLUSH = 5'h04,
    ST_TAIL = 5'h08,
    ST_RESP = 5'h10
  } acgw_state_t;

  acgw_state_t state_q, state_d;
  acgw_pkg::acgw_cmd_t cmd_q, letter_cmd, net_cmd;
  acgw_pkg::acgw_req_t req_d, req_q;
  acgw_pkg::acgw_rsp_t rsp;
  logic local_q, hdr_q, req_v_q;
  logic [3:0] nidx_q;
  logic [1:0] step_q;
  logic [15:0] count_q, bit_q, chars_q, hund_q;
  logic [31:0] tick_q;
  logic [7:0] low_c;
  logic rx_fire, is_digit, in_parse, is_text, is_num_cmd, size_hit;
  logic timeout, term, tick_hit, acc_dig, acc_clr, acc_act, num_take;
  logic first_num, num_emit, hdr_print, txt_emit, tail_v, tail_emit;
  logic req_load, req_rdy, bit_ok, bit_val, rsp_v, rsp_rdy, rsp_fire;
  logic addr_ack, ack_cr, fmt_start, fmt_nodig, fmt_busy, route_store;
  logic [15:0] acc_val, bit_mask, tail_val, fmt_val;
  logic [7:0] fmt_tail;

  // Receive decode
  assign rx_fire = rx_valid_in && rx_ready_out;
  assign low_c = rx_data_in | acgw_pkg::CASE_BIT;
  assign is_digit = rx_data_in >= acgw_pkg::CH_0 && rx_data_in <= acgw_pkg::CH_9;
  assign letter_cmd = (low_c == acgw_pkg::LET_R) ? acgw_pkg::CMD_READ :
                      (low_c == acgw_pkg::LET_W) ? acgw_pkg::CMD_WRITE :
                      (low_c == acgw_pkg::LET_S) ? acgw_pkg::CMD_SET :
                      (low_c == acgw_pkg::LET_C) ? acgw_pkg::CMD_CLR :
                      (low_c == acgw_pkg::LET_B) ? acgw_pkg::CMD_BIT :
                      (low_c == acgw_pkg::LET_P) ? acgw_pkg::CMD_PRINT :
                      (low_c == acgw_pkg::LET_O) ? acgw_pkg::CMD_OMIT :
                      (low_c == acgw_pkg::LET_A) ? acgw_pkg::CMD_ADDR :
                      acgw_pkg::CMD_NONE;
  assign in_parse = state_q == ST_PARSE;
  assign is_text = cmd_q == acgw_pkg::CMD_PRINT || cmd_q == acgw_pkg::CMD_OMIT;
  assign is_num_cmd = !is_text && cmd_q != acgw_pkg::CMD_NONE;
  // Held off while a request beat waits, so no character is lost
  assign rx_ready_out = !req_v_q && (state_q == ST_IDLE || in_parse);

  // Command termination
  assign size_hit = pkt_size_limit_in != 16'h0000 &&
                    (chars_q + 16'h0001) >= pkt_size_limit_in;
  assign timeout = in_parse && pkt_time_limit_in != 16'h0000 &&
                   hund_q >= pkt_time_limit_in;
  assign tick_hit = tick_q >= 32'(TICK_CYCLES - 1);
  assign term = (in_parse && rx_fire &&
                 (rx_data_in == acgw_pkg::CH_CR || size_hit)) ||
                timeout;

  // Numbers: non-digits close a number and are otherwise skipped
  assign acc_dig = in_parse && rx_fire && is_num_cmd && is_digit;
  assign num_take = acc_act && ((in_parse && rx_fire && !is_digit) ||
                    (state_q == ST_FLUSH && !req_v_q));
  assign acc_clr = num_take || state_q == ST_IDLE;
  assign first_num = nidx_q == 4'h0;
  assign num_emit = num_take &&
                    ((first_num && cmd_q != acgw_pkg::CMD_ADDR) ||
                     (!first_num && cmd_q == acgw_pkg::CMD_WRITE));
  assign route_store = num_take && cmd_q == acgw_pkg::CMD_ADDR &&
                       nidx_q < acgw_pkg::ROUTE_MAX;

  acgw_dec_acc u_acc (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clear_in(acc_clr),
    .digit_valid_in(acc_dig),
    .digit_in(rx_data_in[3:0]),
    .value_out(acc_val),
    .active_out(acc_act)
  );

  // Bit numbers run 1..16; out of range gives an empty mask
  assign bit_ok = bit_q != 16'h0000 && bit_q <= acgw_pkg::BIT_LAST;
  assign bit_mask = bit_ok ? (16'h0001 << (bit_q[3:0] - 4'h1)) : 16'h0000;

  // Closing beats: count or mask, CR LF for print, then end marker
  assign tail_v = step_q == 2'h2 ||
                  (step_q == 2'h1 && cmd_q == acgw_pkg::CMD_PRINT) ||
                  (step_q == 2'h0 && cmd_q != acgw_pkg::CMD_WRITE &&
                   cmd_q != acgw_pkg::CMD_OMIT);
  assign tail_val = (step_q == 2'h2) ? 16'h0000 :
                    (step_q == 2'h1) ? {8'h00, acgw_pkg::CH_LF} :
                    (cmd_q == acgw_pkg::CMD_READ) ? count_q :
                    (cmd_q == acgw_pkg::CMD_BIT) ? acgw_pkg::COUNT_RST :
                    (cmd_q == acgw_pkg::CMD_PRINT) ? {8'h00, acgw_pkg::CH_CR} :
                    bit_mask;
  assign tail_emit = state_q == ST_TAIL && hdr_q && !req_v_q && tail_v &&
                     cmd_q != acgw_pkg::CMD_ADDR;

  // Request beat assembly
  assign hdr_print = state_q == ST_IDLE && rx_fire &&
                     (letter_cmd == acgw_pkg::CMD_PRINT ||
                      letter_cmd == acgw_pkg::CMD_OMIT);
  assign txt_emit = in_parse && rx_fire && is_text;
  assign req_load = hdr_print || txt_emit || num_emit || tail_emit;
  assign net_cmd = (cmd_q == acgw_pkg::CMD_BIT) ? acgw_pkg::CMD_READ : cmd_q;
  assign req_d.cmd = hdr_print ? letter_cmd : net_cmd;
  assign req_d.beat = (hdr_print || (num_emit && first_num)) ?
                      acgw_pkg::BEAT_HDR :
                      (tail_emit && step_q == 2'h2) ? acgw_pkg::BEAT_END :
                      acgw_pkg::BEAT_DATA;
  assign req_d.value = hdr_print ? 16'h0000 :
                       txt_emit ? {8'h00, rx_data_in} :
                       num_emit ? acc_val : tail_val;
  assign req_rdy = local_q ? loc_req_ready_in : net_req_ready_in;
  assign net_req_valid_out = req_v_q && !local_q;
  assign loc_req_valid_out = req_v_q && local_q;
  assign req_out = req_q;

  // Responses from whichever side served the command
  assign rsp = local_q ? loc_rsp_in : net_rsp_in;
  assign rsp_v = local_q ? loc_rsp_valid_in : net_rsp_valid_in;
  assign rsp_rdy = state_q == ST_RESP && !fmt_busy;
  assign net_rsp_ready_out = rsp_rdy && !local_q;
  assign loc_rsp_ready_out = rsp_rdy && local_q;
  assign rsp_fire = rsp_rdy && rsp_v;
  assign bit_val = bit_ok && rsp.data[bit_q[3:0] - 4'h1];

  // Replies to the host
  assign addr_ack = state_q == ST_TAIL && cmd_q == acgw_pkg::CMD_ADDR &&
                    !fmt_busy;
  assign ack_cr = rsp_fire && rsp.last &&
                  (cmd_q == acgw_pkg::CMD_WRITE || cmd_q == acgw_pkg::CMD_SET ||
                   cmd_q == acgw_pkg::CMD_CLR);
  assign fmt_nodig = addr_ack || ack_cr;
  assign fmt_start = fmt_nodig || (rsp_fire &&
                     (cmd_q == acgw_pkg::CMD_READ || cmd_q == acgw_pkg::CMD_BIT));
  assign fmt_val = (cmd_q == acgw_pkg::CMD_BIT) ? {15'h0000, bit_val} : rsp.data;
  assign fmt_tail = (cmd_q == acgw_pkg::CMD_READ && !rsp.last) ?
                    acgw_pkg::CH_SP : acgw_pkg::CH_CR;

  acgw_dec_fmt u_fmt (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .start_in(fmt_start),
    .value_in(fmt_val),
    .nodig_in(fmt_nodig),
    .tail_in(fmt_tail),
    .busy_out(fmt_busy),
    .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out),
    .tx_ready_in(tx_ready_in)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rx_fire && letter_cmd != acgw_pkg::CMD_NONE) state_d = ST_PARSE;
      end
      ST_PARSE: begin
        if (term) state_d = ST_FLUSH;
      end
      ST_FLUSH: begin
        if (!acc_act || num_take) state_d = ST_TAIL;
      end
      ST_TAIL: begin
        if (cmd_q == acgw_pkg::CMD_ADDR) begin
          if (!fmt_busy) state_d = ST_IDLE;
        end else if (!hdr_q) begin
          state_d = ST_IDLE;
        end else if (tail_emit && step_q == 2'h2) begin
          state_d = is_text ? ST_IDLE : ST_RESP;
        end
      end
      ST_RESP: begin
        if (rsp_fire && rsp.last) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      req_v_q <= 1'b0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      if (req_load) req_q <= req_d;
      req_v_q <= req_load || (req_v_q && !req_rdy);
    end
  end

  // Command context captured at the letter
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cmd_q <= acgw_pkg::CMD_NONE;
      local_q <= 1'b0;
      hdr_q <= 1'b0;
      nidx_q <= 4'h0;
      step_q <= 2'h0;
      count_q <= acgw_pkg::COUNT_RST;
      bit_q <= 16'h0000;
      chars_q <= 16'h0000;
    end else if (state_q == ST_IDLE && rx_fire) begin
      cmd_q <= letter_cmd;
      local_q <= route_out.len == 4'h0;
      hdr_q <= hdr_print;
      nidx_q <= 4'h0;
      step_q <= 2'h0;
      count_q <= acgw_pkg::COUNT_RST;
      bit_q <= 16'h0000;
      chars_q <= 16'h0001;
    end else begin
      if (in_parse && rx_fire) chars_q <= chars_q + 16'h0001;
      if (num_emit) hdr_q <= 1'b1;
      if (num_take && nidx_q != 4'hf) nidx_q <= nidx_q + 4'h1;
      if (num_take && nidx_q == 4'h1) begin
        count_q <= acc_val;
        bit_q <= acc_val;
      end
      if (state_q == ST_TAIL && !req_v_q) step_q <= step_q + 2'h1;
    end
  end

  // Idle gap timer in hundredths, restarted by every character
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !in_parse || rx_fire) begin
      tick_q <= 32'h0000_0000;
      hund_q <= 16'h0000;
    end else if (tick_hit) begin
      tick_q <= 32'h0000_0000;
      hund_q <= hund_q + 16'h0001;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  // Config write wins over a drop stored in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      route_out <= '0;
    end else if (route_we_in) begin
      route_out <= route_in;
    end else if (state_q == ST_IDLE && rx_fire &&
                 letter_cmd == acgw_pkg::CMD_ADDR) begin
      route_out.len <= 4'h0;
    end else if (route_store) begin
      route_out.drop[nidx_q[2:0]] <= acc_val[7:0];
      route_out.len <= nidx_q + 4'h1;
    end
  end

  cr_ends_cmd_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    in_parse && rx_fire && rx_data_in == acgw_pkg::CH_CR |=> state_q == ST_FLUSH)
    else $error("CR did not end the command");
  size_limit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    in_parse && rx_fire && pkt_size_limit_in != 16'h0000 &&
    chars_q + 16'h0001 == pkt_size_limit_in |=> state_q == ST_FLUSH)
    else $error("size limit did not end the command");
  req_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_v_q && !req_rdy |=> req_v_q && $stable(req_q))
    else $error("request beat changed while stalled");
  local_path_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_q == ST_IDLE && rx_fire |=>
    local_q == ($past(route_out.len) == 4'h0))
    else $error("serving side not taken from route at the letter");
  read_hdr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    in_parse && rx_fire && !is_digit && acc_act && first_num &&
    cmd_q == acgw_pkg::CMD_READ |=> req_v_q &&
    req_q.beat == acgw_pkg::BEAT_HDR && req_q.value == $past(acc_val))
    else $error("read header not the register number");
  mask_onehot_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_v_q && req_q.beat == acgw_pkg::BEAT_DATA &&
    (req_q.cmd == acgw_pkg::CMD_SET || req_q.cmd == acgw_pkg::CMD_CLR) |->
    $onehot0(req_q.value))
    else $error("bit request mask not a single bit");
  print_char_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    txt_emit |=> req_v_q && req_q.beat == acgw_pkg::BEAT_DATA &&
    req_q.value[7:0] == $past(rx_data_in))
    else $error("print character not forwarded");
  omit_exact_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tail_emit && cmd_q == acgw_pkg::CMD_OMIT |-> step_q == 2'h2)
    else $error("omit appended extra characters");
  addr_reply_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    addr_ack |=> fmt_busy ##[1:20] tx_valid_out && tx_data_out == acgw_pkg::CH_CR)
    else $error("address command not answered with CR");
endmodule : acgw_gateway
`default_nettype wire

// ===== bench/acgw_host_model.sv
// Host terminal model: sends queued characters, collects replies
`timescale 1ns/1ps
`default_nettype none
module acgw_host_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Characters to the gateway
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  // Replies from the gateway
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // Each character held until taken
  always @(posedge clk_sys_in) begin
    if (rx_valid_out && rx_ready_in) send_q.delete(0);
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
    rx_valid_out <= !rst_in && send_q.size() != 0;
    // Idle line inverts its data every cycle, never holds a stale copy
    rx_data_out <= send_q.size() != 0 ? send_q[0] : ~rx_data_out;
    // Slow reader now and then
    tx_ready_out <= $urandom_range(3) != 0;
  end
endmodule : acgw_host_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the ASCII command gateway
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_in, rst_in, route_we, exp_loc, on_loc;
  logic rx_v, rx_r, tx_v, tx_r, net_v, net_r, loc_v, loc_r;
  logic net_rv, loc_rv, net_rr, loc_rr;
  logic [7:0] rx_d, tx_d, prt[$];
  logic [15:0] size_lim, time_lim, v, dq[$], mem[int];
  acgw_pkg::acgw_route_t route_in, route_out;
  acgw_pkg::acgw_req_t req;
  acgw_pkg::acgw_rsp_t rsp, rq[$];
  int failures, num_checks, hdr;

  acgw_gateway #(.TICK_CYCLES(4)) u_acgw_gateway (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .rx_valid_in(rx_v), .rx_data_in(rx_d), .rx_ready_out(rx_r),
    .tx_valid_out(tx_v), .tx_data_out(tx_d), .tx_ready_in(tx_r),
    .pkt_size_limit_in(size_lim), .pkt_time_limit_in(time_lim),
    .route_we_in(route_we), .route_in(route_in), .route_out(route_out),
    .req_out(req), .net_req_valid_out(net_v), .net_req_ready_in(net_r),
    .loc_req_valid_out(loc_v), .loc_req_ready_in(loc_r),
    .net_rsp_valid_in(net_rv), .net_rsp_in(rsp), .net_rsp_ready_out(net_rr),
    .loc_rsp_valid_in(loc_rv), .loc_rsp_in(rsp), .loc_rsp_ready_out(loc_rr));

  acgw_host_model u_acgw_host_model (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .rx_valid_out(rx_v), .rx_data_out(rx_d), .rx_ready_in(rx_r),
    .tx_valid_in(tx_v), .tx_data_in(tx_d), .tx_ready_out(tx_r));

  task automatic check(string what, string exp, string got);
    num_checks++;
    if (exp != got) begin
      failures++;
      $display("ERROR %s expected %s seen %s", what, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Register store and printer behind the route
  task automatic take(acgw_pkg::acgw_req_t r);
    case (r.beat)
      acgw_pkg::BEAT_HDR: begin
        hdr = r.value;
        dq = {};
      end
      acgw_pkg::BEAT_DATA: dq.push_back(r.value);
      default: case (r.cmd)
        acgw_pkg::CMD_READ: for (int i = 0; i < dq[0]; i++)
          rq.push_back({mem[hdr + i], i == dq[0] - 1});
        acgw_pkg::CMD_WRITE: begin
          foreach (dq[i]) mem[hdr + i] = dq[i];
          rq.push_back(17'h00001);
        end
        acgw_pkg::CMD_SET, acgw_pkg::CMD_CLR: begin
          mem[hdr] = r.cmd == acgw_pkg::CMD_SET ? mem[hdr] | dq[0]
                                                : mem[hdr] & ~dq[0];
          rq.push_back(17'h00001);
        end
        default: foreach (dq[i]) prt.push_back(dq[i][7:0]);
      endcase
    endcase
  endtask : take

  always @(posedge clk_sys_in) begin
    if ((net_rv && net_rr) || (loc_rv && loc_rr)) rq.delete(0);
    if ((net_v && net_r) || (loc_v && loc_r)) begin
      on_loc = loc_v;
      check("side", $sformatf("%b", exp_loc), $sformatf("%b", loc_v));
      take(req);
    end
    net_r <= $urandom_range(1);
    loc_r <= $urandom_range(1);
    net_rv <= !rst_in && rq.size() != 0 && !on_loc;
    loc_rv <= !rst_in && rq.size() != 0 && on_loc;
    rsp <= rq.size() != 0 ? rq[0] : ~rsp;
  end

  // Sends one command, then compares reply and printed text
  task automatic cmd(string s, string rep, string pr);
    string got;
    int n;
    got = "";
    @(negedge clk_sys_in);
    u_acgw_host_model.got_q = {};
    prt = {};
    for (int i = 0; i < s.len(); i++)
      u_acgw_host_model.send_q.push_back(s[i]);
    for (n = 0; n < 3000; n++) begin
      if (u_acgw_host_model.got_q.size() >= rep.len() &&
          prt.size() >= pr.len()) break;
      @(posedge clk_sys_in);
    end
    if (n == 3000) begin
      failures++;
      wrap_up();
    end
    // Late extra characters must show up too
    repeat (80) @(posedge clk_sys_in);
    foreach (u_acgw_host_model.got_q[i])
      got = $sformatf("%s%c", got, u_acgw_host_model.got_q[i]);
    check("reply", rep, got);
    got = "";
    foreach (prt[i]) got = $sformatf("%s%c", got, prt[i]);
    check("print", pr, got);
  endtask : cmd

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    void'($urandom(32'h3b42));
    {rst_in, exp_loc} = 2'b11;
    {route_we, on_loc, net_r, loc_r, net_rv, loc_rv} = '0;
    route_in = '0;
    rsp = '0;
    size_lim = 16'h0080;
    // Long gap limit: beat stalls must not look like host silence
    time_lim = 16'h0008;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    v = 16'($urandom_range(65535));
    cmd("W 12 55=67,9\015", "\015", "");
    cmd("Ralph 12 for 2\015", "55 67\015", "");
    cmd("s12.1\015", "\015", "");
    cmd("SET 12 16\015", "\015", "");
    cmd("c12,1\015", "\015", "");
    cmd("r12\015", "32822\015", "");
    cmd("b12 16\015", "1\015", "");
    cmd("Bit 12-1\015", "0\015", "");
    cmd("ADDRESS 8 10\015", "\015", "");
    check("len", "2", $sformatf("%0d", route_out.len));
    check("drop", "8 10", $sformatf("%0d %0d", route_out.drop[0],
                                   route_out.drop[1]));
    exp_loc = 1'b0;
    cmd($sformatf("w5 %0d\015", v), "\015", "");
    cmd("R 5\015", $sformatf("%0d\015", v), "");
    cmd("PHi\015", "", "Hi\015\015\n");
    time_lim <= 16'h0005;
    cmd("O+++", "", "+++");
    size_lim <= 16'h0004;
    time_lim <= 16'h0008;
    cmd("pabc", "", "abc\015\n");
    size_lim <= 16'h0080;
    @(posedge clk_sys_in);
    route_in.drop <= {$urandom, $urandom};
    route_we <= 1'b1;
    @(posedge clk_sys_in);
    route_we <= 1'b0;
    @(posedge clk_sys_in);
    check("len", "0", $sformatf("%0d", route_out.len));
    check("route", $sformatf("%h", route_in), $sformatf("%h", route_out));
    exp_loc = 1'b1;
    cmd("r13,2\015", "67 9\015", "");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
